// File: logic/sac_clk_div.sv
`timescale 1ns/1ps
`include "sac_params.svh"
// Builds the one-cycle converter clock enable from the selected source and divider.
module sac_clk_div (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [1:0] i_clock_source_select,
  input wire logic [1:0] i_clock_divide_select,
  input wire logic i_alternate_clock_tick,
  input wire logic i_async_enable,
  output logic o_converter_clock_tick
);
  logic half_q;
  logic [2:0] osc_cnt_q;
  logic osc_tick;
  logic src_tick;
  logic [2:0] div_cnt_q;
  logic [2:0] div_max;

  // Bus clock halved toggles every cycle; only counts while the converter runs.
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  // Internal oscillator lives here and runs only while selected and active; it counts
  // bus clock cycles, so it stalls whenever the bus clock does, like the other sources.
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_async_enable) begin
      osc_cnt_q <= 3'h0;
    end else if (osc_cnt_q == `SAC_ASYNC_HALF) begin
      osc_cnt_q <= 3'h0;
    end else begin
      osc_cnt_q <= osc_cnt_q + 3'h1;
    end
  end
  assign osc_tick = i_async_enable && (osc_cnt_q == `SAC_ASYNC_HALF);

  // Source multiplexer.
  always_comb begin
    case (i_clock_source_select)
      `SAC_CLK_BUS: src_tick = i_run;
      `SAC_CLK_BUS_HALF: src_tick = i_run && half_q;
      `SAC_CLK_ALT: src_tick = i_run && i_alternate_clock_tick;
      default: src_tick = osc_tick;
    endcase
  end

  // Divider of 1, 2, 4 or 8; with the halved bus clock this reaches divide by 16.
  assign div_max = 3'((4'h1 << i_clock_divide_select) - 4'h1);
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      div_cnt_q <= 3'h0;
    end else if (src_tick) begin
      div_cnt_q <= (div_cnt_q >= div_max) ? 3'h0 : div_cnt_q + 3'h1;
    end
  end
  assign o_converter_clock_tick = src_tick && (div_cnt_q >= div_max);
endmodule : sac_clk_div

// File: logic/sac_ctrl.sv
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_ctrl #(
  parameter int PINS = 24
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_status_control_one_wr,
  input wire logic [4:0] i_channel_select_field,
  input wire logic i_done_interrupt_enable,
  input wire logic i_status_control_two_wr,
  input wire logic i_converter_config_wr,
  input wire logic i_compare_value_high_wr,
  input wire logic i_compare_value_low_wr,
  input wire logic i_hw_trigger_enable,
  input wire logic i_continuous_enable,
  input wire logic i_compare_enable,
  input wire logic i_compare_greater,
  input wire logic [9:0] i_compare_value,
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_clock_source_select,
  input wire logic [1:0] i_clock_divide_select,
  input wire logic i_alternate_clock_tick,
  input wire logic i_hw_trigger_input,
  input wire logic i_comparator_high,
  input wire logic i_result_high_rd,
  input wire logic i_result_low_rd,
  input wire logic i_conversion_done_flag_clr,
  input wire logic [PINS-1:0] i_pin_isolate,
  input wire logic [PINS-1:0] i_port_in,
  input wire logic [PINS-1:0] i_port_out_en_n,
  input wire logic [PINS-1:0] i_port_pullup_en,
  output logic [PINS-1:0] o_port_in,
  output logic [PINS-1:0] o_port_out_en_n,
  output logic [PINS-1:0] o_port_pullup_en,
  output logic [PINS-1:0] o_port_input_buf_en,
  output logic o_analog_enable,
  output logic o_sample,
  output logic [10:0] o_trial_code,
  output logic [7:0] o_result_high,
  output logic [7:0] o_result_low,
  output logic o_conversion_done_flag,
  output logic o_interrupt,
  output logic o_busy
);
  sac_pkg::sac_state_e state_q;
  logic conv_tick;
  logic [10:0] sar_q;
  logic [3:0] bit_q;
  logic [3:0] samp_q;
  logic trig_meta_q;
  logic trig_sync_q;
  logic trig_last_q;
  logic trig_rise;
  logic hw_launched_q;
  logic high_read_q;
  logic [9:0] result_q;
  logic done_q;
  logic mode10;
  logic disabled;
  logic abort;
  logic sw_start;
  logic hw_start;
  logic start;
  logic [9:0] rounded;
  logic [10:0] diff;
  logic cmp_true;
  logic blocked;
  logic finishing;
  logic restart;

  // Rounds the approximation by adding half an LSB, saturating at full scale.
  function automatic logic [9:0] sac_round(input logic [10:0] raw, input logic wide);
    logic [10:0] sum;
    sum = 11'h000;
    if (wide) begin
      sum = (raw[10:1] == 10'h3FF) ? {1'b0, 10'h3FF} : {1'b0, raw[10:1]} + {10'h000, raw[0]};
    end else begin
      sum = (raw[10:3] == 8'hFF) ? 11'h0FF : {3'h0, raw[10:3]} + {10'h000, raw[2]};
    end
    return sum[9:0];
  endfunction : sac_round

  // Maps the step counter to the trial bit; 8-bit mode searches only the top nine bits,
  // so the low two bits stay zero and the rounding function ignores them.
  function automatic logic [3:0] sac_bit_index(input logic [3:0] step, input logic wide);
    return wide ? step : step + (`SAC_STEPS_10 - `SAC_STEPS_8);
  endfunction : sac_bit_index

  assign mode10 = (i_mode == `SAC_MODE_10);
  assign disabled = (i_channel_select_field == `SAC_CH_OFF);
  // Writes to status control two, the converter config or either compare value byte invalidate the conversion in progress.
  assign abort = i_status_control_two_wr || i_converter_config_wr ||
                 i_compare_value_high_wr || i_compare_value_low_wr || disabled;
  assign o_busy = (state_q != sac_pkg::SAC_IDLE);

  // Clock selection and division.
  sac_clk_div u_clk_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(o_busy),
    .i_clock_source_select(i_clock_source_select),
    .i_clock_divide_select(i_clock_divide_select),
    .i_alternate_clock_tick(i_alternate_clock_tick),
    .i_async_enable(o_busy && (i_clock_source_select == `SAC_CLK_ASYNC)),
    .o_converter_clock_tick(conv_tick)
  );

  // Two-stage synchroniser then edge detection on the second stage only.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_last_q <= 1'b0;
    end else begin
      trig_meta_q <= i_hw_trigger_input;
      trig_sync_q <= trig_meta_q;
      trig_last_q <= trig_sync_q;
    end
  end
  assign trig_rise = trig_sync_q && !trig_last_q;

  // Start sources; the hardware edge counts only when idle and not yet launched.
  assign sw_start = i_status_control_one_wr && !i_hw_trigger_enable && !disabled;
  assign hw_start = i_hw_trigger_enable && trig_rise && !o_busy && !hw_launched_q && !disabled;
  assign start = sw_start || hw_start;

  // Remembers that a continuous hardware sequence has already been launched.
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_continuous_enable || !i_hw_trigger_enable || abort || i_status_control_one_wr) begin
      hw_launched_q <= 1'b0;
    end else if (hw_start) begin
      hw_launched_q <= 1'b1;
    end
  end

  // Compare against the two's complement of the compare value.
  assign rounded = sac_round(sar_q, mode10);
  assign diff = {1'b0, rounded} + {1'b0, ~i_compare_value} + 11'h001;
  assign cmp_true = !i_compare_enable || (i_compare_greater ? diff[10] : !diff[10]);
  assign blocked = mode10 && high_read_q;
  assign finishing = (state_q == sac_pkg::SAC_FINISH);
  // Blocked transfers retry except single compare-false conversions.
  assign restart = finishing && (i_continuous_enable || (blocked && cmp_true));

  // Conversion sequencer; idle is the low power state.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= sac_pkg::SAC_IDLE;
    end else if (abort && !start) begin
      state_q <= sac_pkg::SAC_IDLE;
    end else if (start) begin
      state_q <= sac_pkg::SAC_SAMPLE;
    end else begin
      case (state_q)
        sac_pkg::SAC_IDLE: state_q <= sac_pkg::SAC_IDLE;
        sac_pkg::SAC_SAMPLE: begin
          if (conv_tick && samp_q == `SAC_SAMPLE_TICKS - 4'h1) begin
            state_q <= sac_pkg::SAC_APPROX;
          end
        end
        sac_pkg::SAC_APPROX: begin
          if (conv_tick && bit_q == 4'h0) begin
            state_q <= sac_pkg::SAC_FINISH;
          end
        end
        sac_pkg::SAC_FINISH: state_q <= restart ? sac_pkg::SAC_SAMPLE : sac_pkg::SAC_IDLE;
        default: state_q <= sac_pkg::SAC_IDLE;
      endcase
    end
  end

  // Sample counter and successive approximation register.
  always_ff @(posedge i_clk) begin
    if (i_rst || start || state_q == sac_pkg::SAC_IDLE || finishing) begin
      samp_q <= 4'h0;
      sar_q <= 11'h000;
      bit_q <= mode10 ? `SAC_STEPS_10 - 4'h1 : `SAC_STEPS_8 - 4'h1;
    end else if (conv_tick && state_q == sac_pkg::SAC_SAMPLE) begin
      samp_q <= samp_q + 4'h1;
      if (samp_q == `SAC_SAMPLE_TICKS - 4'h1) begin
        sar_q[10] <= 1'b1;
      end
    end else if (conv_tick && state_q == sac_pkg::SAC_APPROX) begin
      // Keep the trial bit if the analog comparator says the input is higher.
      sar_q[sac_bit_index(bit_q, mode10)] <= i_comparator_high;
      if (bit_q != 4'h0) begin
        sar_q[sac_bit_index(bit_q, mode10) - 4'h1] <= 1'b1;
        bit_q <= bit_q - 4'h1;
      end
    end
  end
  assign o_trial_code = sar_q;
  assign o_sample = (state_q == sac_pkg::SAC_SAMPLE);
  assign o_analog_enable = o_busy && !disabled;

  // Read tracking for the two-byte result: high read arms the block, low read clears it.
  always_ff @(posedge i_clk) begin
    if (i_rst || i_result_low_rd) begin
      high_read_q <= 1'b0;
    end else if (i_result_high_rd && mode10) begin
      high_read_q <= 1'b1;
    end
  end

  // Result transfer; compare mode stores the difference instead.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      result_q <= `SAC_RST_RESULT;
    end else if (finishing && !blocked && cmp_true) begin
      if (i_compare_enable) begin
        result_q <= mode10 ? diff[9:0] : {2'h0, diff[7:0]};
      end else begin
        result_q <= rounded;
      end
    end
  end
  assign o_result_high = mode10 ? {6'h00, result_q[9:8]} : 8'h00;
  assign o_result_low = result_q[7:0];

  // Done flag: a hardware set wins over a software clear in the same cycle.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_q <= 1'b0;
    end else if (finishing && !blocked && cmp_true) begin
      done_q <= 1'b1;
    end else if (i_conversion_done_flag_clr || i_status_control_one_wr) begin
      done_q <= 1'b0;
    end
  end
  assign o_conversion_done_flag = done_q;
  assign o_interrupt = done_q && i_done_interrupt_enable;

  // Pin isolation forces high-Z, kills input buffer and pullup, reads zero.
  assign o_port_out_en_n = i_port_out_en_n | i_pin_isolate;
  assign o_port_pullup_en = i_port_pullup_en & ~i_pin_isolate;
  assign o_port_input_buf_en = ~i_pin_isolate;
  assign o_port_in = i_port_in & ~i_pin_isolate;
endmodule : sac_ctrl

// File: shared/sac_params.svh
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
// Channel field value that disables the converter.
`define SAC_CH_OFF 5'h1F
// Clock source select encodings.
`define SAC_CLK_BUS 2'h0
`define SAC_CLK_BUS_HALF 2'h1
`define SAC_CLK_ALT 2'h2
`define SAC_CLK_ASYNC 2'h3
// Conversion mode encodings.
`define SAC_MODE_8 2'h0
`define SAC_MODE_10 2'h2
// Reset values of configuration and results.
`define SAC_RST_RESULT 10'h000
`define SAC_RST_CLK_SEL 2'h0
// Approximation steps per conversion, in converter clock ticks, plus sampling.
`define SAC_SAMPLE_TICKS 4'h4
`define SAC_STEPS_10 4'hB
`define SAC_STEPS_8 4'h9
// Internal asynchronous oscillator terminal count; it ticks once every four bus cycles.
`define SAC_ASYNC_HALF 3'h3
`endif

// File: shared/sac_pkg.sv
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_APPROX,
    SAC_FINISH
  } sac_state_e;
endpackage : sac_pkg

// File: tb/sac_analog_model.sv
`timescale 1ns/1ps
// Ideal analog front end: an offset-free comparator, so a 10-bit search settles exactly on the held level.
module sac_analog_model (
  input wire logic [10:0] i_trial_code,
  input wire logic [10:0] i_level,
  output logic o_comparator_high
);
  // The trial bit is kept while the level reaches the trial code; noise is not modelled.
  assign o_comparator_high = (i_level >= i_trial_code);
endmodule : sac_analog_model

// File: tb/sac_ctrl_asserts.sv
`timescale 1ns/1ps
`include "sac_params.svh"
// Port checks of the conversion control; the block has a single bus clock domain.
module sac_ctrl_asserts #(
  parameter int PINS = 24
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_status_control_one_wr,
  input wire logic [4:0] i_channel_select_field,
  input wire logic i_done_interrupt_enable,
  input wire logic i_status_control_two_wr,
  input wire logic i_converter_config_wr,
  input wire logic i_compare_value_high_wr,
  input wire logic i_compare_value_low_wr,
  input wire logic i_hw_trigger_enable,
  input wire logic i_hw_trigger_input,
  input wire logic i_conversion_done_flag_clr,
  input wire logic [PINS-1:0] i_pin_isolate,
  input wire logic [PINS-1:0] i_port_in,
  input wire logic [PINS-1:0] i_port_out_en_n,
  input wire logic [PINS-1:0] o_port_in,
  input wire logic [PINS-1:0] o_port_out_en_n,
  input wire logic [PINS-1:0] o_port_input_buf_en,
  input wire logic [7:0] o_result_high,
  input wire logic [7:0] o_result_low,
  input wire logic o_conversion_done_flag,
  input wire logic o_interrupt,
  input wire logic o_busy
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // The trigger passes a synchroniser, so an idle edge must not start at once but soon after.
  sequence s_trig_idle;
    $rose(i_hw_trigger_input) && i_hw_trigger_enable && !o_busy && !i_status_control_one_wr;
  endsequence
  sequence s_late_start;
    !o_busy ##[1:4] o_busy;
  endsequence
  a_isolate_read: assert property (o_port_in == (i_port_in & ~i_pin_isolate))
    else $error("isolated pin read is not zero");
  a_isolate_drive: assert property (o_port_out_en_n == (i_port_out_en_n | i_pin_isolate)
      && o_port_input_buf_en == ~i_pin_isolate)
    else $error("isolated pin still driven or sensed");
  a_irq_flag: assert property (o_interrupt == (o_conversion_done_flag && i_done_interrupt_enable))
    else $error("interrupt does not follow flag");
  a_reset_clear: assert property ($fell(i_rst) |-> !o_busy && !o_conversion_done_flag
      && {o_result_high, o_result_low} == 16'h0000)
    else $error("state not cleared by reset");
  a_off_channel: assert property (i_status_control_one_wr
      && i_channel_select_field == `SAC_CH_OFF |=> !o_busy)
    else $error("converter ran with channel off");
  a_sw_start: assert property (i_status_control_one_wr && !i_hw_trigger_enable
      && i_channel_select_field != `SAC_CH_OFF |=> o_busy)
    else $error("write did not start");
  a_abort_write: assert property ((i_status_control_two_wr || i_converter_config_wr
      || i_compare_value_high_wr || i_compare_value_low_wr) && !i_status_control_one_wr |=> !o_busy)
    else $error("conversion not aborted");
  a_flag_stands: assert property (o_conversion_done_flag && !i_conversion_done_flag_clr
      && !i_status_control_one_wr |=> o_conversion_done_flag)
    else $error("flag dropped by itself");
  a_result_flag: assert property ($changed({o_result_high, o_result_low}) |-> o_conversion_done_flag)
    else $error("result changed without flag");
  a_trig_synced: assert property (s_trig_idle |=> s_late_start)
    else $error("trigger start timing wrong");
endmodule : sac_ctrl_asserts

// File: tb/sar_adc_conversion_control_tb.sv
`timescale 1ns/1ps
`include "sac_params.svh"
// Reset and pin checks first, then table-driven conversions, then blocking, continuous, trigger and compare cases.
module sar_adc_conversion_control_tb;
  localparam int PINS = 24;
  typedef struct packed {
    logic [1:0] md;
    logic [1:0] sr;
    logic [1:0] dv;
    logic [10:0] lv;
    logic [15:0] ex;
  } sac_row_s;
  logic clk, rst, hwen, cont, cmpen, cmpgt, irqen, hwtrig, cmp_hi, flag, irq, busy, samp, aen;
  logic alt = 1'b0;
  logic [1:0] acnt = 2'h0;
  logic [7:0] strb, rh, rl;
  logic [4:0] ch;
  logic [9:0] cv;
  logic [1:0] mode, src, dv;
  logic [10:0] lvl, trial;
  logic [PINS-1:0] iso, pin, poe, ppu, q_in, q_oe, q_pu, q_ib;
  int n_fail = 0;
  int comparisons = 0;
  // Even levels, except the saturating 11'h7FF, keep rounding unambiguous; every source and divider appears at least once.
  sac_row_s rows [5] = '{'{`SAC_MODE_10, `SAC_CLK_BUS, 2'h0, 11'h2AA, 16'h0155},
    '{`SAC_MODE_10, `SAC_CLK_BUS_HALF, 2'h1, 11'h7FE, 16'h03FF},
    '{`SAC_MODE_8, `SAC_CLK_ALT, 2'h2, 11'h7FF, 16'h00FF},
    '{`SAC_MODE_8, `SAC_CLK_ASYNC, 2'h3, 11'h000, 16'h0000},
    '{`SAC_MODE_10, `SAC_CLK_BUS, 2'h3, 11'h400, 16'h0200}};
  sac_ctrl #(.PINS(PINS)) dut (.i_clk(clk), .i_rst(rst), .i_status_control_one_wr(strb[0]),
    .i_channel_select_field(ch), .i_done_interrupt_enable(irqen), .i_status_control_two_wr(strb[1]),
    .i_converter_config_wr(strb[2]), .i_compare_value_high_wr(strb[3]), .i_compare_value_low_wr(strb[4]),
    .i_hw_trigger_enable(hwen), .i_continuous_enable(cont), .i_compare_enable(cmpen), .i_compare_greater(cmpgt),
    .i_compare_value(cv), .i_mode(mode), .i_clock_source_select(src), .i_clock_divide_select(dv),
    .i_alternate_clock_tick(alt), .i_hw_trigger_input(hwtrig), .i_comparator_high(cmp_hi),
    .i_result_high_rd(strb[5]), .i_result_low_rd(strb[6]), .i_conversion_done_flag_clr(strb[7]),
    .i_pin_isolate(iso), .i_port_in(pin), .i_port_out_en_n(poe), .i_port_pullup_en(ppu), .o_port_in(q_in),
    .o_port_out_en_n(q_oe), .o_port_pullup_en(q_pu), .o_port_input_buf_en(q_ib), .o_analog_enable(aen),
    .o_sample(samp), .o_trial_code(trial), .o_result_high(rh), .o_result_low(rl), .o_conversion_done_flag(flag),
    .o_interrupt(irq), .o_busy(busy));
  sac_analog_model far (.i_trial_code(trial), .i_level(lvl), .o_comparator_high(cmp_hi));
  // Free-running bus clock and an alternate clock enable every fourth cycle.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    acnt <= acnt + 2'h1;
    alt <= (acnt == 2'h3);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Strobes are one-cycle pulses; holding a bit longer would look like two writes.
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    strb <= m;
    @(posedge clk);
    strb <= 8'h00;
  endtask : pulse
  // Looks at the flag only once the edge has settled, so a flag left from the last run is not mistaken.
  task automatic wait_done(input int lim);
    int k;
    k = 0;
    #1;
    while (flag !== 1'b1 && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wait_done
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Cut a hang short well beyond the longest expected run.
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {rst, hwen, cont, cmpen, cmpgt, irqen, hwtrig} = 7'h40;
    {strb, ch, cv, mode, src, dv, lvl, iso, poe} = '0;
    {pin, ppu} = '1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("busy", busy, 1'b0);
    check("flag", flag, 1'b0);
    check("result", {rh, rl}, 16'h0000);
    @(posedge clk);
    iso <= 24'hA5_00FF;
    ch <= `SAC_CH_OFF;
    pulse(8'h01);
    repeat (3) @(posedge clk);
    #1;
    check("busy", busy, 1'b0);
    check("port in", q_in, 24'h5A_FF00);
    check("out enable", q_oe, 24'hA5_00FF);
    check("pullup", q_pu, 24'h5A_FF00);
    check("input buffer", q_ib, 24'h5A_FF00);
    ch <= 5'h00;
    $display("reset and pin test done");
    for (int r = 0; r < 5; r++) begin
      @(posedge clk);
      {mode, src, dv, lvl} <= {rows[r].md, rows[r].sr, rows[r].dv, rows[r].lv};
      irqen <= r[0];
      pulse(8'h01);
      wait_done(800);
      check("flag", flag, 1'b1);
      check("irq", irq, r[0]);
      check("result", {rh, rl}, rows[r].ex);
      $display("row %0d done", r);
    end
    // A half-read result blocks the transfer; the low read lets a restarted conversion land.
    @(posedge clk);
    lvl <= 11'h2AA;
    pulse(8'h20);
    pulse(8'h01);
    wait_done(400);
    check("flag", flag, 1'b0);
    check("result", {rh, rl}, 16'h0200);
    pulse(8'h40);
    wait_done(800);
    check("result", {rh, rl}, 16'h0155);
    $display("blocking test done");
    cont <= 1'b1;
    pulse(8'h01);
    wait_done(800);
    pulse(8'h80);
    wait_done(800);
    check("flag", flag, 1'b1);
    pulse(8'h02);
    cont <= 1'b0;
    #1;
    check("busy", busy, 1'b0);
    $display("continuous test done");
    // A second trigger edge during the conversion must not queue another one.
    pulse(8'h80);
    hwen <= 1'b1;
    hwtrig <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("busy", busy, 1'b1);
    check("sample", samp, 1'b1);
    check("analog", aen, 1'b1);
    hwtrig <= 1'b0;
    repeat (3) @(posedge clk);
    hwtrig <= 1'b1;
    wait_done(800);
    check("flag", flag, 1'b1);
    repeat (30) @(posedge clk);
    #1;
    check("busy", busy, 1'b0);
    check("analog", aen, 1'b0);
    hwen <= 1'b0;
    hwtrig <= 1'b0;
    $display("trigger test done");
    {cmpen, cmpgt, cv, lvl} <= {2'h3, 10'h3FF, 11'h400};
    pulse(8'h08);
    pulse(8'h01);
    wait_done(400);
    check("flag", flag, 1'b0);
    check("busy", busy, 1'b0);
    check("result", {rh, rl}, 16'h0155);
    cv <= 10'h100;
    pulse(8'h10);
    pulse(8'h01);
    wait_done(800);
    check("flag", flag, 1'b1);
    check("result", {rh, rl}, 16'h0100);
    cmpen <= 1'b0;
    $display("compare test done");
    report_and_stop();
  end
endmodule : sar_adc_conversion_control_tb
bind sac_ctrl sac_ctrl_asserts #(.PINS(PINS)) chk (.*);
